//--- hw/dcr_register_bank.sv
`timescale 1ns/1ps
`default_nettype none

module dcr_register_bank (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire dcr_pkg::dcr_req_s req,
  input wire logic [7:0] ch1_sample,
  input wire logic [7:0] ch2_sample,
  input wire logic [7:0] ch3_sample,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic regs_initialized,
  output logic [11:0] pll_feedback_divider,
  output logic power_down_all,
  output dcr_pkg::dcr_regs_s config_regs
);
  import dcr_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [7:0] write_mask(input logic [7:0] a);
    logic [7:0] m;
    m = 8'h00;
    if (a == ADDR_LINE_LENGTH_LOW) begin
      m = MASK_FULL;
    end else if (a == ADDR_LINE_LENGTH_HIGH) begin
      m = MASK_NIBBLE;
    end else if (a == ADDR_CLAMP_CONTROL) begin
      m = MASK_CLAMP_CONTROL;
    end else if (a == ADDR_CLAMP_BEGIN_HIGH) begin
      m = MASK_NIBBLE;
    end else if (a == ADDR_CLAMP_END_HIGH) begin
      m = MASK_NIBBLE;
    end else if (a == ADDR_PIXEL_CAPTURE_HIGH) begin
      m = MASK_NIBBLE;
    end else if (a == ADDR_CH1_GAIN_ROUGH) begin
      m = MASK_GAIN_ROUGH;
    end else if (a == ADDR_CH2_GAIN_ROUGH) begin
      m = MASK_GAIN_ROUGH;
    end else if (a == ADDR_CH3_GAIN_ROUGH) begin
      m = MASK_GAIN_ROUGH;
    end else if (a == ADDR_CH1_GAIN_TRIM) begin
      m = MASK_GAIN_TRIM;
    end else if (a == ADDR_CH2_GAIN_TRIM) begin
      m = MASK_GAIN_TRIM;
    end else if (a == ADDR_CH3_GAIN_TRIM) begin
      m = MASK_GAIN_TRIM;
    end else if (a == ADDR_POWER_DOWN_CONTROL) begin
      m = MASK_POWER_DOWN;
    end else if (a == ADDR_AUXILIARY_CONTROL) begin
      m = MASK_AUXILIARY;
    end else if (a == ADDR_OUTPUT_FORMAT_CONTROL) begin
      m = MASK_OUTPUT_FORMAT;
    end else if (a == ADDR_CLAMP_BEGIN_LOW) begin
      m = MASK_FULL;
    end else if (a == ADDR_CLAMP_END_LOW) begin
      m = MASK_FULL;
    end else if (a == ADDR_CH1_CLAMP_LEVEL) begin
      m = MASK_FULL;
    end else if (a == ADDR_CH2_CLAMP_LEVEL) begin
      m = MASK_FULL;
    end else if (a == ADDR_CH3_CLAMP_LEVEL) begin
      m = MASK_FULL;
    end else if (a == ADDR_PIXEL_CAPTURE_LOW) begin
      m = MASK_FULL;
    end
    return m;
  endfunction

  function automatic logic [7:0] read_byte(input dcr_regs_s r, input logic [7:0] a,
                                           input logic [7:0] s1, input logic [7:0] s2,
                                           input logic [7:0] s3);
    logic [7:0] d;
    d = 8'h00;
    if (a == ADDR_LINE_LENGTH_LOW) begin
      d = r.line_length_low;
    end else if (a == ADDR_LINE_LENGTH_HIGH) begin
      d = r.line_length_high;
    end else if (a == ADDR_CLAMP_CONTROL) begin
      d = r.clamp_control;
    end else if (a == ADDR_CLAMP_BEGIN_LOW) begin
      d = r.clamp_begin_low;
    end else if (a == ADDR_CLAMP_BEGIN_HIGH) begin
      d = r.clamp_begin_high;
    end else if (a == ADDR_CLAMP_END_LOW) begin
      d = r.clamp_end_low;
    end else if (a == ADDR_CLAMP_END_HIGH) begin
      d = r.clamp_end_high;
    end else if (a == ADDR_CH1_CLAMP_LEVEL) begin
      d = r.ch1_clamp_level;
    end else if (a == ADDR_CH1_GAIN_ROUGH) begin
      d = r.ch1_gain_rough;
    end else if (a == ADDR_CH1_GAIN_TRIM) begin
      d = r.ch1_gain_trim;
    end else if (a == ADDR_CH2_CLAMP_LEVEL) begin
      d = r.ch2_clamp_level;
    end else if (a == ADDR_CH2_GAIN_ROUGH) begin
      d = r.ch2_gain_rough;
    end else if (a == ADDR_CH2_GAIN_TRIM) begin
      d = r.ch2_gain_trim;
    end else if (a == ADDR_CH3_CLAMP_LEVEL) begin
      d = r.ch3_clamp_level;
    end else if (a == ADDR_CH3_GAIN_ROUGH) begin
      d = r.ch3_gain_rough;
    end else if (a == ADDR_CH3_GAIN_TRIM) begin
      d = r.ch3_gain_trim;
    end else if (a == ADDR_PIXEL_CAPTURE_LOW) begin
      d = r.pixel_capture_low;
    end else if (a == ADDR_PIXEL_CAPTURE_HIGH) begin
      d = r.pixel_capture_high;
    end else if (a == ADDR_POWER_DOWN_CONTROL) begin
      d = r.power_down_control;
    end else if (a == ADDR_AUXILIARY_CONTROL) begin
      d = r.auxiliary_control;
    end else if (a == ADDR_CH1_SAMPLE_READBACK) begin
      d = s1;
    end else if (a == ADDR_CH2_SAMPLE_READBACK) begin
      d = s2;
    end else if (a == ADDR_CH3_SAMPLE_READBACK) begin
      d = s3;
    end else if (a == ADDR_OUTPUT_FORMAT_CONTROL) begin
      d = r.output_format_control;
    end
    return d;
  endfunction

  function automatic logic is_readback(input logic [7:0] a);
    return a >= ADDR_CH1_SAMPLE_READBACK && a <= ADDR_CH3_SAMPLE_READBACK;
  endfunction

  function automatic logic is_reserved(input logic [7:0] a);
    return a > ADDR_CH3_SAMPLE_READBACK && a < ADDR_OUTPUT_FORMAT_CONTROL;
  endfunction

  // ****************************************
  // Reset values
  // ****************************************
  function automatic dcr_regs_s default_regs();
    dcr_regs_s r;
    r.line_length_low = RST_LINE_LENGTH_LOW;
    r.line_length_high = RST_LINE_LENGTH_HIGH;
    r.clamp_control = RST_OTHER;
    r.clamp_begin_low = RST_OTHER;
    r.clamp_begin_high = RST_OTHER;
    r.clamp_end_low = RST_OTHER;
    r.clamp_end_high = RST_OTHER;
    r.ch1_clamp_level = RST_OTHER;
    r.ch1_gain_rough = RST_OTHER;
    r.ch1_gain_trim = RST_OTHER;
    r.ch2_clamp_level = RST_OTHER;
    r.ch2_gain_rough = RST_OTHER;
    r.ch2_gain_trim = RST_OTHER;
    r.ch3_clamp_level = RST_OTHER;
    r.ch3_gain_rough = RST_OTHER;
    r.ch3_gain_trim = RST_OTHER;
    r.pixel_capture_low = RST_OTHER;
    r.pixel_capture_high = RST_OTHER;
    r.power_down_control = RST_OTHER;
    r.auxiliary_control = RST_OTHER;
    r.output_format_control = RST_OTHER;
    return r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  dcr_state_s st;
  dcr_state_s next_st;
  logic [7:0] addr;
  logic [7:0] mask;
  logic [7:0] merged;

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    addr = req.start ? req.addr : st.pointer;
    mask = write_mask(addr);
    merged = req.wdata & mask;
    if (req.wr_en) begin
      // Readback and reserved addresses have an all-zero mask and store nothing
      if (mask != 8'h00 && !is_readback(addr) && !is_reserved(addr)) begin
        if (addr == ADDR_LINE_LENGTH_LOW) begin
          next_st.regs.line_length_low = merged;
        end else if (addr == ADDR_LINE_LENGTH_HIGH) begin
          next_st.regs.line_length_high = merged;
        end else if (addr == ADDR_CLAMP_CONTROL) begin
          next_st.regs.clamp_control = merged;
        end else if (addr == ADDR_CLAMP_BEGIN_LOW) begin
          next_st.regs.clamp_begin_low = merged;
        end else if (addr == ADDR_CLAMP_BEGIN_HIGH) begin
          next_st.regs.clamp_begin_high = merged;
        end else if (addr == ADDR_CLAMP_END_LOW) begin
          next_st.regs.clamp_end_low = merged;
        end else if (addr == ADDR_CLAMP_END_HIGH) begin
          next_st.regs.clamp_end_high = merged;
        end else if (addr == ADDR_CH1_CLAMP_LEVEL) begin
          next_st.regs.ch1_clamp_level = merged;
        end else if (addr == ADDR_CH1_GAIN_ROUGH) begin
          next_st.regs.ch1_gain_rough = merged;
        end else if (addr == ADDR_CH1_GAIN_TRIM) begin
          next_st.regs.ch1_gain_trim = merged;
        end else if (addr == ADDR_CH2_CLAMP_LEVEL) begin
          next_st.regs.ch2_clamp_level = merged;
        end else if (addr == ADDR_CH2_GAIN_ROUGH) begin
          next_st.regs.ch2_gain_rough = merged;
        end else if (addr == ADDR_CH2_GAIN_TRIM) begin
          next_st.regs.ch2_gain_trim = merged;
        end else if (addr == ADDR_CH3_CLAMP_LEVEL) begin
          next_st.regs.ch3_clamp_level = merged;
        end else if (addr == ADDR_CH3_GAIN_ROUGH) begin
          next_st.regs.ch3_gain_rough = merged;
        end else if (addr == ADDR_CH3_GAIN_TRIM) begin
          next_st.regs.ch3_gain_trim = merged;
        end else if (addr == ADDR_PIXEL_CAPTURE_LOW) begin
          next_st.regs.pixel_capture_low = merged;
        end else if (addr == ADDR_PIXEL_CAPTURE_HIGH) begin
          next_st.regs.pixel_capture_high = merged;
        end else if (addr == ADDR_POWER_DOWN_CONTROL) begin
          next_st.regs.power_down_control = merged;
        end else if (addr == ADDR_AUXILIARY_CONTROL) begin
          next_st.regs.auxiliary_control = merged;
        end else if (addr == ADDR_OUTPUT_FORMAT_CONTROL) begin
          next_st.regs.output_format_control = merged;
        end
      end
      next_st.pointer = addr + 8'h01;
    end else if (req.rd_en) begin
      next_st.rdata = read_byte(st.regs, addr, ch1_sample, ch2_sample, ch3_sample);
      next_st.rvalid = 1'b1;
      next_st.pointer = addr + 8'h01;
    end else if (req.start) begin
      next_st.pointer = req.addr;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // Only reset gives defined contents; power-down never touches them
      st.regs <= default_regs();
      st.pointer <= 8'h00;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
      st.initialized <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign regs_initialized = st.initialized;
  assign pll_feedback_divider = {st.regs.line_length_high[3:0], st.regs.line_length_low};
  assign power_down_all = st.regs.power_down_control[PWDN_ALL_BIT];
  assign config_regs = st.regs;

endmodule

`default_nettype wire

//--- hw/dcr_pkg.sv
`default_nettype none
package dcr_pkg;

  // ****************************************
  // Subaddresses
  // ****************************************
  localparam logic [7:0] ADDR_LINE_LENGTH_LOW = 8'h00;
  localparam logic [7:0] ADDR_LINE_LENGTH_HIGH = 8'h01;
  localparam logic [7:0] ADDR_CLAMP_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_CLAMP_BEGIN_LOW = 8'h21;
  localparam logic [7:0] ADDR_CLAMP_BEGIN_HIGH = 8'h22;
  localparam logic [7:0] ADDR_CLAMP_END_LOW = 8'h23;
  localparam logic [7:0] ADDR_CLAMP_END_HIGH = 8'h24;
  localparam logic [7:0] ADDR_CH1_CLAMP_LEVEL = 8'h25;
  localparam logic [7:0] ADDR_CH1_GAIN_ROUGH = 8'h26;
  localparam logic [7:0] ADDR_CH1_GAIN_TRIM = 8'h27;
  localparam logic [7:0] ADDR_CH2_CLAMP_LEVEL = 8'h28;
  localparam logic [7:0] ADDR_CH2_GAIN_ROUGH = 8'h29;
  localparam logic [7:0] ADDR_CH2_GAIN_TRIM = 8'h2A;
  localparam logic [7:0] ADDR_CH3_CLAMP_LEVEL = 8'h2B;
  localparam logic [7:0] ADDR_CH3_GAIN_ROUGH = 8'h2C;
  localparam logic [7:0] ADDR_CH3_GAIN_TRIM = 8'h2D;
  localparam logic [7:0] ADDR_PIXEL_CAPTURE_LOW = 8'h2E;
  localparam logic [7:0] ADDR_PIXEL_CAPTURE_HIGH = 8'h2F;
  localparam logic [7:0] ADDR_POWER_DOWN_CONTROL = 8'h30;
  localparam logic [7:0] ADDR_AUXILIARY_CONTROL = 8'h31;
  localparam logic [7:0] ADDR_CH1_SAMPLE_READBACK = 8'h32;
  localparam logic [7:0] ADDR_CH2_SAMPLE_READBACK = 8'h33;
  localparam logic [7:0] ADDR_CH3_SAMPLE_READBACK = 8'h34;
  localparam logic [7:0] ADDR_OUTPUT_FORMAT_CONTROL = 8'h40;

  // ****************************************
  // Implemented bit masks
  // ****************************************
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_NIBBLE = 8'h0F;
  localparam logic [7:0] MASK_CLAMP_CONTROL = 8'h7F;
  localparam logic [7:0] MASK_GAIN_ROUGH = 8'h3F;
  localparam logic [7:0] MASK_GAIN_TRIM = 8'h1F;
  localparam logic [7:0] MASK_POWER_DOWN = 8'h17;
  localparam logic [7:0] MASK_AUXILIARY = 8'h3F;
  localparam logic [7:0] MASK_OUTPUT_FORMAT = 8'h0F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_LINE_LENGTH_LOW = 8'h20;
  localparam logic [7:0] RST_LINE_LENGTH_HIGH = 8'h05;
  // Not given for the remaining registers; neutral zero
  localparam logic [7:0] RST_OTHER = 8'h00;

  // Bit of power_down_control that stops everything
  localparam int PWDN_ALL_BIT = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic start;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dcr_req_s;

  typedef struct packed {
    logic [7:0] line_length_low;
    logic [7:0] line_length_high;
    logic [7:0] clamp_control;
    logic [7:0] clamp_begin_low;
    logic [7:0] clamp_begin_high;
    logic [7:0] clamp_end_low;
    logic [7:0] clamp_end_high;
    logic [7:0] ch1_clamp_level;
    logic [7:0] ch1_gain_rough;
    logic [7:0] ch1_gain_trim;
    logic [7:0] ch2_clamp_level;
    logic [7:0] ch2_gain_rough;
    logic [7:0] ch2_gain_trim;
    logic [7:0] ch3_clamp_level;
    logic [7:0] ch3_gain_rough;
    logic [7:0] ch3_gain_trim;
    logic [7:0] pixel_capture_low;
    logic [7:0] pixel_capture_high;
    logic [7:0] power_down_control;
    logic [7:0] auxiliary_control;
    logic [7:0] output_format_control;
  } dcr_regs_s;

  typedef struct packed {
    dcr_regs_s regs;
    logic [7:0] pointer;
    logic [7:0] rdata;
    logic rvalid;
    logic initialized;
  } dcr_state_s;

endpackage
`default_nettype wire

//--- verification/dcr_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module dcr_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire dcr_pkg::dcr_req_s req,
  input wire logic [7:0] ch1_sample,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic regs_initialized,
  input wire logic [11:0] pll_feedback_divider,
  input wire dcr_pkg::dcr_regs_s config_regs
);
  import dcr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_reset; disable iff (1'b0) sys_rst |=> regs_initialized && pll_feedback_divider == 12'h520; endproperty
  a_reset: assert property (p_reset) else $error("reset default wrong");
  property p_div; pll_feedback_divider == {config_regs.line_length_high[3:0], config_regs.line_length_low}; endproperty
  a_div: assert property (p_div) else $error("divider mismatch");
  property p_mask; config_regs.line_length_high[7:4] == 4'h0 && (config_regs.power_down_control & ~MASK_POWER_DOWN) == 8'h00; endproperty
  a_mask: assert property (p_mask) else $error("unused bits set");
  property p_wr; req.wr_en && req.start && req.addr == ADDR_LINE_LENGTH_LOW |=> config_regs.line_length_low == $past(req.wdata); endproperty
  a_wr: assert property (p_wr) else $error("low byte not written");
  property p_auto; req.wr_en && req.start && req.addr == ADDR_LINE_LENGTH_LOW ##1 req.wr_en && !req.start |=> config_regs.line_length_high == ($past(req.wdata) & MASK_NIBBLE); endproperty
  a_auto: assert property (p_auto) else $error("pointer did not advance");
  property p_rv; 1'b1 |=> rvalid == ($past(req.rd_en) && !$past(req.wr_en)); endproperty
  a_rv: assert property (p_rv) else $error("read strobe wrong");
  property p_ro; req.rd_en && !req.wr_en && req.start && req.addr == ADDR_CH1_SAMPLE_READBACK |=> rdata == $past(ch1_sample); endproperty
  a_ro: assert property (p_ro) else $error("readback value wrong");
  property p_rsv; req.rd_en && !req.wr_en && req.start && req.addr inside {[8'h35:8'h3F]} |=> rdata == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read not zero");
  property p_hold; !req.wr_en |=> $stable(config_regs); endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");
endmodule
bind dcr_register_bank dcr_chk dcr_chk_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .ch1_sample(ch1_sample),
  .rdata(rdata), .rvalid(rvalid), .regs_initialized(regs_initialized),
  .pll_feedback_divider(pll_feedback_divider), .config_regs(config_regs));
`default_nettype wire

//--- verification/dcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Serial host stand-in
// ****
module dcr_host (
  input wire logic ref_clk,
  output dcr_pkg::dcr_req_s req,
  output logic sys_rst
);
  import dcr_pkg::*;
  initial begin
    req = '0;
    sys_rst = 1'b1;
  end
  // Clock keeps running while reset spans five edges
  task automatic reset_bank();
    @(posedge ref_clk);
    #5 sys_rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    #5 sys_rst = 1'b0;
  endtask
  task automatic xfer(input logic wr, input logic st, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #5 req = {wr, !wr, st, a, d};
  endtask
  // Released lines flip so stale values never look valid
  task automatic idle();
    @(posedge ref_clk);
    #5 req = {3'b000, ~req.addr, ~req.wdata};
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Register bank bench
// ****
module testbench;
  import dcr_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst;
  dcr_req_s req;
  logic [7:0] s1 = 8'h00;
  logic [7:0] s2 = 8'h00;
  logic [7:0] s3 = 8'h00;
  logic [7:0] rdata;
  logic rvalid, regs_initialized, power_down_all;
  logic [11:0] pll_feedback_divider;
  dcr_regs_s config_regs;
  logic [7:0] mem [256];
  int n_fail = 0;
  int n_checks = 0;
  always #25 ref_clk = ~ref_clk;
  dcr_host dcr_host_inst (.ref_clk(ref_clk), .req(req), .sys_rst(sys_rst));
  dcr_register_bank dcr_register_bank_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .ch1_sample(s1),
    .ch2_sample(s2), .ch3_sample(s3), .rdata(rdata), .rvalid(rvalid), .regs_initialized(regs_initialized),
    .pll_feedback_divider(pll_feedback_divider), .power_down_all(power_down_all), .config_regs(config_regs));
  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      8'h00, 8'h21, 8'h23, 8'h25, 8'h28, 8'h2B, 8'h2E: return 8'hFF;
      8'h01, 8'h22, 8'h24, 8'h2F, 8'h40: return 8'h0F;
      8'h20: return 8'h7F;
      8'h26, 8'h29, 8'h2C, 8'h31: return 8'h3F;
      8'h27, 8'h2A, 8'h2D: return 8'h1F;
      8'h30: return 8'h17;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] exp_of(input logic [7:0] a);
    case (a)
      8'h32: return s1;
      8'h33: return s2;
      8'h34: return s3;
      default: return mem[a];
    endcase
  endfunction
  task automatic load_defaults();
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
    mem[0] = 8'h20;
    mem[1] = 8'h05;
  endtask
  // Whole map in one auto-advancing burst, wrapping back to zero
  task automatic write_all();
    logic [7:0] d;
    for (int i = 0; i < 256; i++) begin
      d = 8'($urandom);
      dcr_host_inst.xfer(1'b1, i == 0, 8'(i), d);
      mem[i] = d & mask_of(8'(i));
    end
    dcr_host_inst.idle();
  endtask
  task automatic read_all();
    s1 = 8'($urandom);
    s2 = 8'($urandom);
    s3 = 8'($urandom);
    for (int i = 0; i <= 256; i++) begin
      if (i < 256) begin
        dcr_host_inst.xfer(1'b0, i == 0, 8'(i), 8'($urandom));
      end else begin
        dcr_host_inst.idle();
      end
      if (i > 0) begin
        chk({11'h000, rvalid}, 12'h001);
        chk({4'h0, rdata}, {4'h0, exp_of(8'(i - 1))});
      end
    end
  endtask
  task automatic rd1(input logic [7:0] a);
    dcr_host_inst.xfer(1'b0, 1'b1, a, 8'h00);
    dcr_host_inst.idle();
    chk({4'h0, rdata}, {4'h0, exp_of(a)});
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(54366));
    load_defaults();
    dcr_host_inst.reset_bank();
    chk({11'h000, regs_initialized}, 12'h001);
    read_all();
    chk(pll_feedback_divider, 12'h520);
    write_all();
    read_all();
    chk(pll_feedback_divider, {mem[1][3:0], mem[0]});
    chk({4'h0, config_regs.auxiliary_control}, {4'h0, mem[8'h31]});
    chk({4'h0, config_regs.output_format_control}, {4'h0, mem[8'h40]});
    rd1(8'h3A);
    rd1(8'h32);
    rd1(8'h33);
    dcr_host_inst.xfer(1'b1, 1'b1, 8'h30, 8'hFF);
    mem[8'h30] = 8'h17;
    dcr_host_inst.idle();
    chk({11'h000, power_down_all}, 12'h001);
    read_all();
    dcr_host_inst.xfer(1'b1, 1'b1, 8'h30, 8'h00);
    mem[8'h30] = 8'h00;
    read_all();
    dcr_host_inst.reset_bank();
    chk({11'h000, regs_initialized}, 12'h001);
    load_defaults();
    read_all();
    wrap_up();
  end
endmodule
`default_nettype wire
